// *** rtl/rgl_cfg.svh ***
`ifndef RGL_CFG_SVH
`define RGL_CFG_SVH
`define RGL_CLK_MHZ 125
`define RGL_TRIP_FILTER_NS 1000
`define RGL_TRIP_FILTER_CYC ((`RGL_TRIP_FILTER_NS * `RGL_CLK_MHZ + 999) / 1000)
`define RGL_DEGLITCH_NS 2000
`define RGL_DEGLITCH_CYC ((`RGL_DEGLITCH_NS * `RGL_CLK_MHZ + 999) / 1000)
`define RGL_CNT_W 12
`define RGL_NCH 8
`endif

// *** rtl/rgl_ctrl.sv ***
`timescale 1ns/1ps
`include "rgl_cfg.svh"
// How it works
// - Supply below primary trip level for the filter time forces full reset.
// - Supply below secondary trip level forces full reset at once, unfiltered.
// - Low external reset acts like a power-on reset.
// - External reset is ignored while a deployment is in progress.
// - Power-on reset condition shuts down even during a deployment.
// - External reset still low after deployment ends then forces reset.
// - External reset lows shorter than the deglitch time are ignored.
// - Reference resistor above upper or below lower limit forces reset.
// - Loss of logic ground forces reset.
// - Loss of a channel power ground disables that channel's low-side driver.
// - High-side driver of a ground-lost channel keeps working.
// - A channel's ground loss affects no other channel.
// - Channel ground loss shows in that channel's low-side diagnostic result.
// - Loss of analog reference ground forces reset.
// - Per-channel ground handling is replicated for all eight loops.
// - A serial software reset command resets the squib functions.
module rgl_ctrl (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire rgl_pkg::rgl_mon_t I_MON,
    input wire logic I_EXT_RESET_N,
    input wire logic I_DEPLOY_ACTIVE,
    input wire logic I_SW_RESET,
    input wire logic [`RGL_NCH-1:0] I_CH_GND_LOST,
    input wire logic [`RGL_NCH-1:0] I_HS_REQ,
    input wire logic [`RGL_NCH-1:0] I_LS_REQ,
    input wire logic [`RGL_NCH-1:0] I_LS_DIAG_OK,
    output logic O_DEVICE_RESET,
    output logic O_SQUIB_RESET,
    output logic [`RGL_NCH-1:0] O_HS_EN,
    output logic [`RGL_NCH-1:0] O_LS_EN,
    output logic [`RGL_NCH-1:0] O_LS_DIAG_FAIL
);
    localparam int CW = `RGL_CNT_W;
    localparam logic [CW-1:0] FILT_CYC = CW'(`RGL_TRIP_FILTER_CYC);
    localparam logic [CW-1:0] DG_CYC = CW'(`RGL_DEGLITCH_CYC);
    localparam int N = `RGL_NCH;
    localparam int SW = $bits(rgl_pkg::rgl_mon_t) + 2 + N;
    // Synchronisers reset to the idle pin levels, so the reset pin reads released.
    localparam logic [SW-1:0] SYNC_IDLE = SW'(1) << (N + 1);

    // Two-stage synchronisers for every asynchronous input.
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] next_sync1;
    rgl_pkg::rgl_mon_t mon;
    logic ext_rst_n;
    logic deploy;
    logic [N-1:0] gnd_lost;
    always_comb begin
        next_sync1 = {I_MON, I_EXT_RESET_N, I_DEPLOY_ACTIVE, I_CH_GND_LOST};
    end
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
        end
    end
    assign {mon, ext_rst_n, deploy, gnd_lost} = sync2;

    // Filter and deglitch counters; saturating.
    function automatic logic [CW-1:0] sat_count(input logic cond, input logic [CW-1:0] c,
                                                input logic [CW-1:0] lim);
        if (!cond) begin
            sat_count = '0;
        end else if (c < lim) begin
            sat_count = c + CW'(1);
        end else begin
            sat_count = c;
        end
    endfunction : sat_count

    logic [CW-1:0] filt_cnt;
    logic [CW-1:0] dg_cnt;
    logic [CW-1:0] next_filt_cnt;
    logic [CW-1:0] next_dg_cnt;
    logic por_cond;
    logic ext_asserted;
    logic reset_req;
    always_comb begin
        next_filt_cnt = sat_count(mon.supply_below_primary, filt_cnt, FILT_CYC);
        next_dg_cnt = sat_count(!ext_rst_n, dg_cnt, DG_CYC);
    end
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            filt_cnt <= '0;
            dg_cnt <= '0;
        end else begin
            filt_cnt <= next_filt_cnt;
            dg_cnt <= next_dg_cnt;
        end
    end

    always_comb begin
        por_cond = (filt_cnt >= FILT_CYC)
            || mon.supply_below_secondary
            || mon.ref_res_high || mon.ref_res_low
            || mon.logic_gnd_lost
            || mon.analog_gnd_lost;
        ext_asserted = (dg_cnt >= DG_CYC) && !ext_rst_n;
        // Deployment masks only the external reset; once it ends a held reset applies.
        reset_req = por_cond || (ext_asserted && !deploy);
    end

    rgl_pkg::rgl_state_t state;
    rgl_pkg::rgl_state_t next_state;
    always_comb begin
        case (state)
            rgl_pkg::RGL_ST_RESET: next_state = reset_req ? rgl_pkg::RGL_ST_RESET
                                                          : rgl_pkg::RGL_ST_RUN;
            rgl_pkg::RGL_ST_RUN: begin
                if (reset_req) begin
                    next_state = rgl_pkg::RGL_ST_RESET;
                end else if (deploy) begin
                    next_state = rgl_pkg::RGL_ST_DEPLOY;
                end else begin
                    next_state = rgl_pkg::RGL_ST_RUN;
                end
            end
            rgl_pkg::RGL_ST_DEPLOY: begin
                if (reset_req) begin
                    next_state = rgl_pkg::RGL_ST_RESET;
                end else if (!deploy) begin
                    next_state = rgl_pkg::RGL_ST_RUN;
                end else begin
                    next_state = rgl_pkg::RGL_ST_DEPLOY;
                end
            end
            default: next_state = rgl_pkg::RGL_ST_RESET;
        endcase
    end

    logic next_dev_rst;
    logic next_sq_rst;
    logic [N-1:0] next_hs;
    logic [N-1:0] next_ls;
    logic [N-1:0] next_diag;
    always_comb begin
        next_dev_rst = reset_req;
        next_sq_rst = reset_req || I_SW_RESET;
        if (reset_req) begin
            next_hs = '0;
            next_ls = '0;
            next_diag = '0;
        end else begin
            next_hs = I_HS_REQ;
            next_ls = I_LS_REQ & ~gnd_lost;
            next_diag = gnd_lost | ~I_LS_DIAG_OK;
        end
    end
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state <= rgl_pkg::RGL_ST_RESET;
            O_DEVICE_RESET <= 1'h1;
            O_SQUIB_RESET <= 1'h1;
            O_HS_EN <= '0;
            O_LS_EN <= '0;
            O_LS_DIAG_FAIL <= '0;
        end else begin
            state <= next_state;
            O_DEVICE_RESET <= next_dev_rst;
            O_SQUIB_RESET <= next_sq_rst;
            O_HS_EN <= next_hs;
            O_LS_EN <= next_ls;
            O_LS_DIAG_FAIL <= next_diag;
        end
    end

    secondary_trip_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        mon.supply_below_secondary |=> O_DEVICE_RESET && O_HS_EN == '0)
        else $error("secondary trip did not reset");
    primary_filter_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (filt_cnt >= FILT_CYC) |=> O_DEVICE_RESET)
        else $error("filtered supply trip did not reset");
    primary_short_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (filt_cnt < FILT_CYC && !mon.supply_below_secondary && !mon.ref_res_high
         && !mon.ref_res_low && !mon.logic_gnd_lost && !mon.analog_gnd_lost
         && ext_rst_n && !I_SW_RESET) |=> !O_DEVICE_RESET)
        else $error("reset without cause");
    ext_deploy_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (deploy && !por_cond) |=> !O_DEVICE_RESET)
        else $error("external reset acted during deployment");
    ext_after_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (!deploy && ext_asserted) |=> O_DEVICE_RESET)
        else $error("held external reset ignored after deployment");
    deglitch_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        $rose(ext_asserted) |-> !$past(ext_rst_n, 1) && !$past(ext_rst_n, 2))
        else $error("deglitch too short");
    ref_res_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (mon.ref_res_high || mon.ref_res_low) |=> O_DEVICE_RESET ##0 O_LS_EN == '0)
        else $error("reference resistor fault not reset");
    gnd_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (mon.logic_gnd_lost || mon.analog_gnd_lost) |=> O_DEVICE_RESET)
        else $error("ground loss not reset");
    ch_gnd_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        ##1 (O_LS_EN & $past(gnd_lost)) == '0)
        else $error("low side on with ground lost");
    hs_keep_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !reset_req |=> O_HS_EN == $past(I_HS_REQ))
        else $error("high side blocked");
    sw_rst_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_SW_RESET |=> O_SQUIB_RESET)
        else $error("software reset lost");

    // The state register and the device reset output must agree on every cycle.
    reset_state_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state == rgl_pkg::RGL_ST_RESET) == O_DEVICE_RESET)
        else $error("reset state and reset output disagree");
    deploy_run_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state == rgl_pkg::RGL_ST_DEPLOY) |-> !O_DEVICE_RESET)
        else $error("device reset during deployment state");
    ls_mask_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !reset_req |=> O_LS_EN == ($past(I_LS_REQ) & ~$past(gnd_lost)))
        else $error("low side enable wrong for its channel");
    diag_fail_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !reset_req |=> O_LS_DIAG_FAIL == ($past(gnd_lost) | ~$past(I_LS_DIAG_OK)))
        else $error("low side diagnostic result wrong");
    sw_only_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_SW_RESET && !reset_req) |=> !O_DEVICE_RESET)
        else $error("software reset reached device reset");
endmodule : rgl_ctrl

// *** rtl/rgl_pkg.sv ***
package rgl_pkg;
    typedef struct packed {
        logic supply_below_primary;
        logic supply_below_secondary;
        logic ref_res_high;
        logic ref_res_low;
        logic logic_gnd_lost;
        logic analog_gnd_lost;
    } rgl_mon_t;
    typedef enum logic [2:0] {
        RGL_ST_RESET = 3'h1,
        RGL_ST_RUN = 3'h2,
        RGL_ST_DEPLOY = 3'h4
    } rgl_state_t;
endpackage : rgl_pkg

// *** tb/reset_and_ground_loss_control_tb.sv ***
`timescale 1ns/1ps
`include "rgl_cfg.svh"
module reset_and_ground_loss_control_tb;
    logic clk, rst, deploy, sw, dev_rst, sq_rst, ext_n;
    logic [7:0] hs, ls, diag, hs_en, ls_en, dfail, gnd, g;
    logic [15:0] rnd;
    logic [7:0] exp_q[$];
    rgl_pkg::rgl_mon_t mon;
    int failures = 0;
    int samples_checked = 0;
    int i;
    rgl_far rgl_far_inst (.i_clk(clk), .o_mon(mon), .o_ext_reset_n(ext_n), .o_ch_gnd_lost(gnd));
    rgl_ctrl rgl_ctrl_inst (.I_CLK(clk), .I_SYS_RST(rst), .I_MON(mon), .I_EXT_RESET_N(ext_n),
        .I_DEPLOY_ACTIVE(deploy), .I_SW_RESET(sw), .I_CH_GND_LOST(gnd), .I_HS_REQ(hs),
        .I_LS_REQ(ls), .I_LS_DIAG_OK(diag), .O_DEVICE_RESET(dev_rst), .O_SQUIB_RESET(sq_rst),
        .O_HS_EN(hs_en), .O_LS_EN(ls_en), .O_LS_DIAG_FAIL(dfail));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    // Reference model: any settled fault, or a long external reset outside a deployment.
    function automatic logic [7:0] exp_rst(input int faults, input int ext_long, input int dep);
        return (faults != 0 || (ext_long != 0 && dep == 0)) ? 8'h01 : 8'h00;
    endfunction : exp_rst
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_cyc
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    initial begin
        rst = 1'b1;
        deploy = 1'b0;
        sw = 1'b0;
        hs = 8'hFF;
        ls = 8'hFF;
        diag = 8'hFF;
        rnd = 16'hF46C;
        wait_cyc(4);
        rst = 1'b0;
        wait_cyc(`RGL_DEGLITCH_CYC + 5);
        check({7'h00, dev_rst}, exp_rst(0, 0, 0));
        for (i = 0; i < 6; i++) begin
            rgl_far_inst.drive(6'h20 >> i, 1'b1, 8'h00);
            wait_cyc(5);
            check({7'h00, dev_rst}, exp_rst(i, 0, 0));
            wait_cyc(`RGL_TRIP_FILTER_CYC);
            check({7'h00, dev_rst}, exp_rst(1, 0, 0));
            check({7'h00, sq_rst}, 8'h01);
            check(hs_en | ls_en, 8'h00);
            rgl_far_inst.drive('0, 1'b1, 8'h00);
            wait_cyc(5);
            check(hs_en & ls_en, ~exp_rst(0, 0, 0));
        end
        rgl_far_inst.drive('0, 1'b0, 8'h00);
        wait_cyc(`RGL_DEGLITCH_CYC - 10);
        check({7'h00, dev_rst}, exp_rst(0, 0, 0));
        rgl_far_inst.drive('0, 1'b1, 8'h00);
        wait_cyc(5);
        check({7'h00, dev_rst}, exp_rst(0, 0, 0));
        rgl_far_inst.drive('0, 1'b0, 8'h00);
        wait_cyc(`RGL_DEGLITCH_CYC + 5);
        check({7'h00, dev_rst}, exp_rst(0, 1, 0));
        rgl_far_inst.drive('0, 1'b1, 8'h00);
        wait_cyc(5);
        deploy = 1'b1;
        wait_cyc(4);
        rgl_far_inst.drive('0, 1'b0, 8'h00);
        wait_cyc(`RGL_DEGLITCH_CYC + 10);
        check({7'h00, dev_rst}, exp_rst(0, 1, 1));
        check(hs_en, 8'hFF);
        rgl_far_inst.drive(6'h10, 1'b0, 8'h00);
        wait_cyc(5);
        check({7'h00, dev_rst}, exp_rst(1, 1, 1));
        rgl_far_inst.drive('0, 1'b0, 8'h00);
        wait_cyc(5);
        check({7'h00, dev_rst}, exp_rst(0, 1, 1));
        deploy = 1'b0;
        wait_cyc(5);
        check({7'h00, dev_rst}, exp_rst(0, 1, 0));
        rgl_far_inst.drive('0, 1'b1, 8'h00);
        wait_cyc(5);
        sw = 1'b1;
        wait_cyc(2);
        check({6'h00, sq_rst, dev_rst}, 8'h02);
        sw = 1'b0;
        wait_cyc(2);
        check({7'h00, sq_rst}, 8'h00);
        for (i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            g = rnd[7:0];
            hs = rnd[15:8];
            rgl_far_inst.drive('0, 1'b1, g);
            rnd = lfsr(rnd);
            ls = rnd[7:0];
            diag = rnd[15:8];
            exp_q.push_back(hs);
            exp_q.push_back(ls & ~g);
            exp_q.push_back(g | ~diag);
            wait_cyc(4);
            check(hs_en, exp_q.pop_front());
            check(ls_en, exp_q.pop_front());
            check(dfail, exp_q.pop_front());
        end
        rst = 1'b1;
        wait_cyc(2);
        check({6'h00, sq_rst, dev_rst}, 8'h03);
        check(hs_en | ls_en | dfail, 8'h00);
        rst = 1'b0;
        wait_cyc(4);
        check({7'h00, dev_rst}, exp_rst(0, 0, 0));
        check(hs_en, hs);
        print_verdict();
    end
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule : reset_and_ground_loss_control_tb

// *** tb/rgl_far.sv ***
`timescale 1ns/1ps
module rgl_far (
    input wire logic i_clk,
    output rgl_pkg::rgl_mon_t o_mon,
    output logic o_ext_reset_n,
    output logic [7:0] o_ch_gnd_lost
);
    // The external reset pin idles high because of its pull-up.
    initial begin
        o_mon = '0;
        o_ext_reset_n = 1'b1;
        o_ch_gnd_lost = 8'h00;
    end
    // The pins move only at a falling edge, so they never change at a rising edge.
    task automatic drive(input rgl_pkg::rgl_mon_t mon, input logic ext_n, input logic [7:0] gnd);
        @(negedge i_clk);
        o_mon = mon;
        o_ext_reset_n = ext_n;
        o_ch_gnd_lost = gnd;
    endtask : drive
endmodule : rgl_far
